// File: rtl/chg_fault_consts.vh
`ifndef CHG_FAULT_CONSTS_VH
`define CHG_FAULT_CONSTS_VH

// ==========================================================
// Fault codes
`define FLT_NONE 3'h0
`define FLT_VBUS_OVP 3'h1
`define FLT_SLEEP 3'h2
`define FLT_POOR_INPUT 3'h3
`define FLT_BAT_OVP 3'h4
`define FLT_THERMAL 3'h5
`define FLT_TIMER 3'h6
`define FLT_NO_BAT 3'h7

// ==========================================================
// Charge-state bits
`define CST_READY 2'h0
`define CST_CHARGING 2'h1
`define CST_DONE 2'h2
`define CST_FAULT 2'h3

// Input limit code meaning no limit
`define ILIM_NO_LIMIT 2'h3

// ==========================================================
// Timing, clock in kHz, times as printed
`define CLK_KHZ 100000
`define STAT_PULSE_NS 128000
`define STAT_PULSE_CYC ((`STAT_PULSE_NS * (`CLK_KHZ / 1000)) / 1000)
`define SOFT_START_US 1000
`define SOFT_START_CYC (`SOFT_START_US * (`CLK_KHZ / 1000))
`define BAT_OVP_MS 30
`define BAT_OVP_CYC (`BAT_OVP_MS * `CLK_KHZ)
`define DETECT_WIN_MS 32
`define DETECT_WIN_CYC (`DETECT_WIN_MS * `CLK_KHZ)
`define PWRUP_LOAD_MS 500
`define PWRUP_LOAD_CYC (`PWRUP_LOAD_MS * `CLK_KHZ)
`define RETRY_MS 2000
`define RETRY_CYC (`RETRY_MS * `CLK_KHZ)
`define DISCHARGE_MS 262
`define DISCHARGE_CYC (`DISCHARGE_MS * `CLK_KHZ)

`endif

// File: rtl/pulse_timer.v
`timescale 1ns/1ps
// ==========================================================
// Down counter: load starts a run, done pulses once at the end
module pulse_timer #(
    parameter W = 32
) (
    input wire clk_i, // Clock
    input wire nrst_i, // Async reset, active low
    input wire load_i, // Start or restart
    input wire stop_i, // Abort run
    input wire [W-1:0] count_i, // Cycles to run
    output reg busy_o, // Running
    output reg done_o // One-cycle end pulse
);
    reg [W-1:0] cnt_r;

    // Count down and flag the last cycle
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r <= {W{1'b0}};
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (stop_i) begin
                busy_o <= 1'b0;
            end else if (load_i) begin
                cnt_r <= count_i;
                busy_o <= 1'b1;
            end else if (busy_o) begin
                if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // pulse_timer

// File: rtl/charger_protection_fault_monitor.v
`timescale 1ns/1ps
`include "chg_fault_consts.vh"

// Behaviour
// - Supply below battery plus offset but above minimum enters sleep.
// - In sleep the blocking switch body stops reverse current.
// - Undervoltage while charging stops charge, pulses pin, state 11, fault 011.
// - After undervoltage, restart only after recovery and the retry interval.
// - Overvoltage opens input switch, suspends charge, fault 001, state 11, pulse.
// - Overvoltage clears on hysteresis; charging resumes after supply requalified.
// - End-of-charge disabled: no switching pulse for 30 ms above float sets fault 100, state 11 for one cycle, pulse.
// - End-of-charge enabled: termination sets state 10, then detect discharge.
// - Battery above detect threshold after discharge is present; fault 000.
// - Absent after termination: defaults, fault 111, retry later.
// - Below low threshold the battery is charged by a linear source.
// - Power-up detection variant loads battery node 500 ms at power-on.
// - Power-up detect forces float 4 V; above 3.7 V within 32 ms means absent.
// - Power-up absent: high impedance, fault 111, fifteen minute timer disabled.
// - Below detect level for whole 32 ms restores float setting, keeps switching.
// - Non-detect variant charges with defaults at 3.54 V until host or timer.
// - Raised setting: input limit 100 mA for 1 ms unless code 11.
// - With no-limit input, soft-start uses 325 mA charge current for 1 ms.
// - Host sets no-battery supply flag; device clears it on battery insertion.
// - Pin open if disabled or normal, low while charging, 128 us pulse on fault.
// - Fault code in status bits 2:0; 010 sleep, 101 thermal, 110 timer.
// - Latched fault clears on status read or supply power-on reset.
module charger_protection_fault_monitor #(
    parameter PWRUP_DETECT = 1, // Variant with power-up battery detection
    parameter [31:0] RETRY_CYC = `RETRY_CYC, // Retry interval
    parameter [31:0] PWRUP_LOAD_CYC = `PWRUP_LOAD_CYC, // Power-up discharge
    parameter [31:0] DETECT_WIN_CYC = `DETECT_WIN_CYC, // Power-up detect window
    parameter [31:0] BAT_OVP_CYC = `BAT_OVP_CYC, // No-pulse timeout
    parameter [31:0] DISCHARGE_CYC = `DISCHARGE_CYC, // Detection discharge
    parameter [31:0] SOFT_START_CYC = `SOFT_START_CYC // Soft-start length
) (
    input wire clk_i, // Clock 100 MHz
    input wire nrst_i, // Async reset, active low (supply power-on reset)
    input wire vbus_below_sleep_i, // Supply below battery plus sleep offset
    input wire vbus_below_min_i, // Supply below undervoltage threshold
    input wire vbus_above_ovp_i, // Supply above overvoltage trip
    input wire vbus_below_ovp_hyst_i, // Supply 150 mV below trip
    input wire bat_above_float_i, // Battery above float setting
    input wire bat_below_short_i, // Battery below low threshold
    input wire bat_above_detect_i, // Battery above detect threshold / 3.7 V
    input wire term_current_i, // Termination current seen near float
    input wire pwm_pulse_i, // Switching pulse occurred
    input wire thermal_shutdown_i, // Die over temperature
    input wire timer_fault_i, // Safety timer expired
    input wire end_of_charge_enable_i, // Termination enable
    input wire stat_enable_i, // Indicator pin enable
    input wire charge_enable_i, // Charging permitted
    input wire host_write_i, // Host wrote a register (pulse)
    input wire status_read_i, // Host read status (pulse)
    input wire setting_raised_i, // Float, limit or current raised (pulse)
    input wire [1:0] input_current_limit_setting_i, // Input limit code
    input wire no_battery_supply_flag_set_i, // Host sets flag (pulse)
    output reg [2:0] fault_code_o, // Fault code, status bits 2:0
    output reg [1:0] charge_state_o, // Charge-state bits
    output wire stat_o, // Indicator pin output level
    output wire stat_oe_o, // Indicator pin drive enable
    output reg sleep_o, // Sleep state
    output reg reverse_block_o, // Body switch of reverse blocking switch
    output reg input_switch_on_o, // Input switch closed
    output reg pwm_enable_o, // Switching charge active
    output reg linear_charge_o, // Linear current source active
    output reg detect_discharge_o, // Detection discharge current on
    output reg pwrup_load_o, // Power-up discharge load on
    output reg float_force_4v_o, // Float forced to 4 V
    output reg hiz_o, // High impedance state
    output reg load_defaults_o, // Load register defaults (pulse)
    output reg timer15_disable_o, // Fifteen minute timer disabled
    output reg defaults_3v54_o, // Default regulation at 3.54 V
    output reg soft_start_ilim_o, // Input limit dropped to 100 mA
    output reg soft_start_325_o, // Soft-start charge current 325 mA
    output reg no_battery_supply_flag_o // No-battery supply flag
);
    localparam [2:0] S_PWRUP = 3'h0;
    localparam [2:0] S_DETECT = 3'h1;
    localparam [2:0] S_CHARGE = 3'h2;
    localparam [2:0] S_DISCH = 3'h3;
    localparam [2:0] S_RETRY = 3'h4;
    localparam [2:0] S_HIZ = 3'h5;
    localparam [2:0] S_OVP = 3'h6;
    localparam [2:0] S_DONE = 3'h7;

    // ==========================================================
    // Input synchronisers: three stages, change counts on 2nd and 3rd agree
    localparam N = 12;
    wire [N-1:0] raw_w = {vbus_below_sleep_i, vbus_below_min_i, vbus_above_ovp_i,
        vbus_below_ovp_hyst_i, bat_above_float_i, bat_below_short_i, bat_above_detect_i,
        term_current_i, pwm_pulse_i, thermal_shutdown_i, timer_fault_i, charge_enable_i};
    reg [N-1:0] s1_r;
    reg [N-1:0] s2_r;
    reg [N-1:0] s3_r;
    reg [N-1:0] q_r;
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_r <= {N{1'b0}};
            s2_r <= {N{1'b0}};
            s3_r <= {N{1'b0}};
            q_r <= {N{1'b0}};
        end else begin
            s1_r <= raw_w;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= (s2_r & s3_r) | (q_r & (s2_r | s3_r));
        end
    end
    wire lo_sleep = q_r[11];
    wire uv = q_r[10];
    wire ovp = q_r[9];
    wire ovp_hyst = q_r[8];
    wire above_float = q_r[7];
    wire below_short = q_r[6];
    wire above_det = q_r[5];
    wire term_cur = q_r[4];
    wire pulse = q_r[3];
    wire therm = q_r[2];
    wire tmr_flt = q_r[1];
    wire chg_en = q_r[0];

    // ==========================================================
    // State and timers
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg t_load;
    reg [31:0] t_count;
    wire t_busy;
    wire t_done;
    wire pwrup_done;
    pulse_timer #(.W(32)) u_state_tmr (
        .clk_i(clk_i), .nrst_i(nrst_i), .load_i(t_load), .stop_i(state_r == S_HIZ),
        .count_i(t_count), .busy_o(t_busy), .done_o(t_done));

    // No-pulse watchdog restarts on every switching pulse
    wire ovp_tmr_done;
    pulse_timer #(.W(32)) u_nopulse_tmr (
        .clk_i(clk_i), .nrst_i(nrst_i),
        .load_i(pulse | ~above_float),
        .stop_i(~pwm_enable_o), .count_i(BAT_OVP_CYC), .busy_o(),
        .done_o(ovp_tmr_done));

    // Soft-start window
    wire ss_busy;
    pulse_timer #(.W(32)) u_ss_tmr (
        .clk_i(clk_i), .nrst_i(nrst_i), .load_i(setting_raised_i), .stop_i(1'b0),
        .count_i(SOFT_START_CYC), .busy_o(ss_busy), .done_o());

    // Indicator pulse timer
    reg stat_fire;
    wire stat_busy;
    pulse_timer #(.W(32)) u_stat_tmr (
        .clk_i(clk_i), .nrst_i(nrst_i), .load_i(stat_fire), .stop_i(1'b0),
        .count_i(`STAT_PULSE_CYC), .busy_o(stat_busy), .done_o());

    reg therm_d_r;
    reg tmr_d_r;
    reg ovp_d_r;
    reg uv_d_r;
    reg sleep_d_r;
    reg bat_was_absent_r;

    // Events that raise a fault, fixed priority, overvoltage first
    reg [2:0] new_code;
    reg new_fault;
    always @* begin
        state_nxt = state_r;
        t_load = 1'b0;
        t_count = 32'h0;
        new_fault = 1'b0;
        new_code = `FLT_NONE;
        case (state_r)
            S_PWRUP: begin
                if (pwrup_done) begin
                    state_nxt = S_DETECT;
                    t_load = 1'b1;
                    t_count = DETECT_WIN_CYC;
                end
            end
            S_DETECT: begin
                if (below_short) begin
                    t_load = 1'b1; // window begins once switching starts
                    t_count = DETECT_WIN_CYC;
                end else if (above_det && t_busy) begin
                    state_nxt = S_HIZ;
                    new_fault = 1'b1;
                    new_code = `FLT_NO_BAT;
                end else if (t_done) begin
                    state_nxt = S_CHARGE;
                end
            end
            S_CHARGE: begin
                if (end_of_charge_enable_i && above_float && term_cur) begin
                    state_nxt = S_DISCH;
                    t_load = 1'b1;
                    t_count = DISCHARGE_CYC;
                end
            end
            S_DISCH: begin
                if (t_done) begin
                    if (above_det) begin
                        state_nxt = S_DONE;
                    end else begin
                        state_nxt = S_RETRY;
                        t_load = 1'b1;
                        t_count = RETRY_CYC;
                        new_fault = 1'b1;
                        new_code = `FLT_NO_BAT;
                    end
                end
            end
            S_RETRY: begin
                if (t_done && !uv) begin
                    state_nxt = S_CHARGE;
                end else if (t_done) begin
                    t_load = 1'b1;
                    t_count = RETRY_CYC;
                end
            end
            S_OVP: begin
                if (ovp_hyst && !ovp) begin
                    state_nxt = S_RETRY; // requalify before charge
                    t_load = 1'b1;
                    t_count = RETRY_CYC;
                end
            end
            S_HIZ: begin
                state_nxt = S_HIZ;
            end
            default: begin
                state_nxt = S_DONE;
            end
        endcase
        // Supply faults override the sequence
        if (ovp && !ovp_d_r && state_r != S_HIZ) begin
            state_nxt = S_OVP;
            new_fault = 1'b1;
            new_code = `FLT_VBUS_OVP;
        end else if (uv && !uv_d_r && (state_r == S_CHARGE || state_r == S_DETECT)) begin
            state_nxt = S_RETRY;
            t_load = 1'b1;
            t_count = RETRY_CYC;
            new_fault = 1'b1;
            new_code = `FLT_POOR_INPUT;
        end else if (ovp_tmr_done && above_float && !end_of_charge_enable_i) begin
            new_fault = 1'b1;
            new_code = `FLT_BAT_OVP;
        end else if (therm && !therm_d_r) begin
            new_fault = 1'b1;
            new_code = `FLT_THERMAL;
        end else if (tmr_flt && !tmr_d_r) begin
            new_fault = 1'b1;
            new_code = `FLT_TIMER;
        end else if (lo_sleep && !uv && !sleep_d_r) begin
            new_fault = 1'b1;
            new_code = `FLT_SLEEP;
        end
    end

    // ==========================================================
    // Sequencer and fault register
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= S_PWRUP;
            fault_code_o <= `FLT_NONE;
            ovp_d_r <= 1'b0;
            uv_d_r <= 1'b0;
            therm_d_r <= 1'b0;
            tmr_d_r <= 1'b0;
            sleep_d_r <= 1'b0;
            stat_fire <= 1'b0;
            load_defaults_o <= 1'b0;
            timer15_disable_o <= 1'b0;
            no_battery_supply_flag_o <= 1'b0;
            bat_was_absent_r <= 1'b0;
            defaults_3v54_o <= 1'b0;
        end else begin
            state_r <= (PWRUP_DETECT == 0 && state_r == S_PWRUP) ? S_CHARGE : state_nxt;
            ovp_d_r <= ovp;
            uv_d_r <= uv;
            therm_d_r <= therm;
            tmr_d_r <= tmr_flt;
            sleep_d_r <= lo_sleep && !uv;
            stat_fire <= new_fault;
            load_defaults_o <= new_fault && new_code == `FLT_NO_BAT && state_r == S_DISCH;
            // New fault wins over a status read in the same cycle
            if (new_fault) begin
                fault_code_o <= new_code;
            end else if (status_read_i) begin
                fault_code_o <= `FLT_NONE;
            end else if (state_r == S_DISCH && t_done && above_det) begin
                fault_code_o <= `FLT_NONE;
            end
            if (state_nxt == S_HIZ && state_r == S_DETECT) begin
                timer15_disable_o <= 1'b1;
            end
            if (PWRUP_DETECT == 0) begin
                defaults_3v54_o <= !(host_write_i || tmr_flt) && defaults_3v54_o
                    | (state_r == S_PWRUP);
            end
            bat_was_absent_r <= below_short;
            // Set by host; insertion clears it, insertion wins
            if (bat_was_absent_r && !below_short && above_det) begin
                no_battery_supply_flag_o <= 1'b0;
            end else if (no_battery_supply_flag_set_i) begin
                no_battery_supply_flag_o <= 1'b1;
            end
        end
    end

    // Power-up load kick
    reg pwrup_kick_r;
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pwrup_kick_r <= 1'b0;
        end else begin
            pwrup_kick_r <= 1'b1;
        end
    end

    // ==========================================================
    // Power path and status outputs
    wire charging = (state_r == S_CHARGE || state_r == S_DETECT) && chg_en && !lo_sleep;
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            charge_state_o <= `CST_READY;
            sleep_o <= 1'b0;
            reverse_block_o <= 1'b0;
            input_switch_on_o <= 1'b0;
            pwm_enable_o <= 1'b0;
            linear_charge_o <= 1'b0;
            detect_discharge_o <= 1'b0;
            pwrup_load_o <= 1'b0;
            float_force_4v_o <= 1'b0;
            hiz_o <= 1'b0;
            soft_start_ilim_o <= 1'b0;
            soft_start_325_o <= 1'b0;
        end else begin
            sleep_o <= lo_sleep && !uv;
            reverse_block_o <= lo_sleep && !uv;
            input_switch_on_o <= state_r != S_OVP && !ovp && state_r != S_HIZ;
            linear_charge_o <= charging && below_short;
            pwm_enable_o <= charging && !below_short && !therm;
            detect_discharge_o <= state_r == S_DISCH;
            pwrup_load_o <= state_r == S_PWRUP && PWRUP_DETECT != 0;
            float_force_4v_o <= state_r == S_DETECT;
            hiz_o <= state_r == S_HIZ;
            soft_start_ilim_o <= ss_busy && input_current_limit_setting_i != `ILIM_NO_LIMIT;
            soft_start_325_o <= ss_busy && input_current_limit_setting_i == `ILIM_NO_LIMIT;
            if (state_r == S_OVP || state_r == S_RETRY || state_r == S_HIZ || new_fault) begin
                charge_state_o <= `CST_FAULT;
            end else if (state_r == S_DISCH || state_r == S_DONE) begin
                charge_state_o <= `CST_DONE;
            end else if (charging) begin
                charge_state_o <= `CST_CHARGING;
            end else begin
                charge_state_o <= `CST_READY;
            end
        end
    end

    // Power-up load runs once right after reset release
    reg pwrup_started_r;
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pwrup_started_r <= 1'b0;
        end else if (pwrup_kick_r) begin
            pwrup_started_r <= 1'b1;
        end
    end
    wire pwrup_load_start = pwrup_kick_r && !pwrup_started_r;
    pulse_timer #(.W(32)) u_pwrup_tmr (
        .clk_i(clk_i), .nrst_i(nrst_i), .load_i(pwrup_load_start),
        .stop_i(state_r != S_PWRUP),
        .count_i(PWRUP_LOAD_CYC), .busy_o(), .done_o(pwrup_done));

    // Open-drain indicator: pulse high-open on fault, low while charging
    assign stat_o = 1'b0;
    assign stat_oe_o = !stat_busy && stat_enable_i && charge_state_o == `CST_CHARGING;

endmodule // charger_protection_fault_monitor

// File: dv/chg_fault_checker.sv
`timescale 1ns/1ps
`include "chg_fault_consts.vh"
// ==========================================================
// Port checks of the fault monitor
module chg_fault_checker (
    input wire clk_i, // Clock
    input wire nrst_i, // Reset
    input wire vbus_below_sleep_i, // Sleep band
    input wire vbus_below_min_i, // Undervoltage
    input wire vbus_above_ovp_i, // Overvoltage
    input wire stat_enable_i, // Pin enable
    input wire [1:0] input_current_limit_setting_i, // Limit code
    input wire [2:0] fault_code_o, // Fault code
    input wire [1:0] charge_state_o, // State bits
    input wire stat_o, // Pin level
    input wire stat_oe_o, // Pin drive
    input wire sleep_o, // Sleep
    input wire reverse_block_o, // Body switch
    input wire input_switch_on_o, // Input switch
    input wire pwm_enable_o, // Switching
    input wire linear_charge_o, // Linear
    input wire pwrup_load_o, // Power-up load
    input wire soft_start_ilim_o, // 100 mA
    input wire soft_start_325_o // 325 mA
);
    localparam int PMAX = `STAT_PULSE_CYC + 4;
    reg [15:0] pulse_cnt_r;
    reg [2:0] code_r;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // ==========================================================
    // Pin released while charging, restarted by a new fault
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pulse_cnt_r <= 16'h0;
            code_r <= 3'h0;
        end else begin
            code_r <= fault_code_o;
            if (stat_oe_o || !stat_enable_i || charge_state_o != 2'h1 || fault_code_o != code_r)
                pulse_cnt_r <= 16'h0;
            else
                pulse_cnt_r <= pulse_cnt_r + 16'h1;
        end
    end
    // ==========================================================
    // Assertions
    sleep_entry_a: assert property ((vbus_below_sleep_i && !vbus_below_min_i) [*8] |-> sleep_o)
        else $error("sleep not entered");
    sleep_block_a: assert property (sleep_o |-> reverse_block_o)
        else $error("no reverse block");
    uv_code_a: assert property (($rose(vbus_below_min_i) && charge_state_o == 2'h1)
        |-> ##[1:8] (fault_code_o == 3'h3 && charge_state_o == 2'h3))
        else $error("uv fault missing");
    ovp_switch_a: assert property (vbus_above_ovp_i [*8] |-> !input_switch_on_o)
        else $error("switch closed in ovp");
    ovp_code_a: assert property ($rose(vbus_above_ovp_i) |-> ##[1:8] fault_code_o == 3'h1)
        else $error("ovp code missing");
    linear_only_a: assert property (linear_charge_o |-> !pwm_enable_o)
        else $error("linear with switching");
    pwrup_hold_a: assert property (pwrup_load_o |-> !pwm_enable_o)
        else $error("switching in power-up load");
    ss_limit_a: assert property (soft_start_ilim_o |-> input_current_limit_setting_i != 2'h3)
        else $error("limit drop with code 11");
    ss_current_a: assert property (soft_start_325_o |-> input_current_limit_setting_i == 2'h3)
        else $error("325 mA without code 11");
    pin_level_a: assert property (stat_oe_o |-> !stat_o)
        else $error("pin driven high");
    fault_pulse_a: assert property (($changed(fault_code_o) && fault_code_o != 3'h0)
        |-> ##[1:3] !stat_oe_o)
        else $error("no pulse on fault");
    pulse_len_a: assert property (stat_enable_i |-> pulse_cnt_r <= PMAX)
        else $error("pulse too long");
endmodule // chg_fault_checker

bind charger_protection_fault_monitor chg_fault_checker u_chk (.clk_i, .nrst_i,
    .vbus_below_sleep_i, .vbus_below_min_i, .vbus_above_ovp_i, .stat_enable_i,
    .input_current_limit_setting_i, .fault_code_o, .charge_state_o, .stat_o, .stat_oe_o,
    .sleep_o, .reverse_block_o, .input_switch_on_o, .pwm_enable_o, .linear_charge_o,
    .pwrup_load_o, .soft_start_ilim_o, .soft_start_325_o);

// File: dv/supply_model.sv
`timescale 1ns/1ps
// ==========================================================
// Supply comparators: 0 normal, 1 sleep band, 2 undervoltage, 3 overvoltage
module supply_model (
    input wire [1:0] mode_i, // Supply condition
    output wire below_sleep_o, // Sleep band
    output wire below_min_o, // Below minimum
    output wire above_ovp_o, // Above trip
    output wire below_hyst_o // Below hysteresis
);
    // Collapsed supply is in the sleep band too
    assign below_sleep_o = (mode_i == 2'h1) || (mode_i == 2'h2);
    assign below_min_o = (mode_i == 2'h2);
    assign above_ovp_o = (mode_i == 2'h3);
    assign below_hyst_o = (mode_i != 2'h3);
endmodule // supply_model

// File: dv/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run = tests_run + 1; if ((g) !== (e)) begin \
    errors = errors + 1; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
`define WAITFOR(c) begin n = 0; while (!(c) && n < 400) begin @(negedge clk_i); n = n + 1; end end
`define W(t) repeat (t) @(negedge clk_i);
`define P(s) begin s = 1'b1; @(negedge clk_i); s = 1'b0; end
module testbench;
    reg clk_i, nrst_i, bflt, bshort, bdet, term, pwm, therm, tmr, eoc, chen, hw, rd, raised, nbf;
    reg [1:0] mode, ilim;
    reg sten;
    integer seed, errors, tests_run, cyc, n, i, k, start;
    wire sl, mn, ov, hy, oe, isw, rb, det, pl, f4, hiz, t15, ssi, ss3, nbo, lin;
    wire [2:0] fc;
    wire [1:0] cs;
    // ==========================================================
    // Design, supply model, clock
    supply_model u_sup (.mode_i(mode), .below_sleep_o(sl), .below_min_o(mn),
        .above_ovp_o(ov), .below_hyst_o(hy));
    charger_protection_fault_monitor #(.RETRY_CYC(32'd50), .PWRUP_LOAD_CYC(32'd50),
        .DETECT_WIN_CYC(32'd50), .BAT_OVP_CYC(32'd50), .DISCHARGE_CYC(32'd50),
        .SOFT_START_CYC(32'd50)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i),
        .vbus_below_sleep_i(sl), .vbus_below_min_i(mn), .vbus_above_ovp_i(ov),
        .vbus_below_ovp_hyst_i(hy), .bat_above_float_i(bflt), .bat_below_short_i(bshort),
        .bat_above_detect_i(bdet), .term_current_i(term), .pwm_pulse_i(pwm),
        .thermal_shutdown_i(therm), .timer_fault_i(tmr), .end_of_charge_enable_i(eoc),
        .stat_enable_i(sten), .charge_enable_i(chen), .host_write_i(hw), .status_read_i(rd),
        .setting_raised_i(raised), .input_current_limit_setting_i(ilim),
        .no_battery_supply_flag_set_i(nbf), .fault_code_o(fc), .charge_state_o(cs),
        .stat_o(), .stat_oe_o(oe), .sleep_o(), .reverse_block_o(rb), .input_switch_on_o(isw),
        .pwm_enable_o(), .linear_charge_o(lin), .detect_discharge_o(det), .pwrup_load_o(pl),
        .float_force_4v_o(f4), .hiz_o(hiz), .load_defaults_o(), .timer15_disable_o(t15),
        .defaults_3v54_o(), .soft_start_ilim_o(ssi), .soft_start_325_o(ss3),
        .no_battery_supply_flag_o(nbo));
    always #5 clk_i = ~clk_i;
    // Switching pulses stop above float
    always @(negedge clk_i) begin
        pwm <= !bflt && ({$random(seed)} % 2 != 0);
        hw <= ({$random(seed)} % 97 == 0);
    end
    // Hang guard
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            end_sim;
        end
    end
    // ==========================================================
    // Expected code per condition
    function [2:0] code_of(input integer j);
        case (j)
            0: code_of = 3'h1;
            1: code_of = 3'h2;
            2: code_of = 3'h3;
            3: code_of = 3'h5;
            4: code_of = 3'h6;
            default: code_of = 3'h4;
        endcase
    endfunction
    // Raise or drop one fault condition
    task drive(input integer j, input reg v);
        case (j)
            0: mode = v ? 2'h3 : 2'h0;
            1: mode = v ? 2'h1 : 2'h0;
            2: mode = v ? 2'h2 : 2'h0;
            3: therm = v;
            4: tmr = v;
            default: bflt = v;
        endcase
    endtask
    task end_sim;
        if (errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        seed = 32'h370b;
        {clk_i, nrst_i, bflt, bshort, bdet, term, pwm, therm, tmr, eoc, hw, rd, raised, nbf} = 0;
        {mode, ilim} = 4'h0;
        {chen, sten} = 2'h3;
        {errors, tests_run, cyc} = 0;
        `W(4)
        nrst_i = 1'b1;
        `W(10)
        `CHK(pl, 1'b1)
        `WAITFOR(pl === 1'b0 && f4 === 1'b0)
        `W(20)
        `CHK(f4, 1'b0)
        `CHK(hiz, 1'b0)
        start = {$random(seed)} % 6;
        for (k = 0; k < 6; k = k + 1) begin
            i = (start + k) % 6;
            drive(i, 1'b1);
            `WAITFOR(fc === code_of(i))
            `CHK(fc, code_of(i))
            if (i == 0 || i == 2 || i == 5) `CHK(cs, 2'h3)
            if (i == 0) `CHK(isw, 1'b0)
            if (i == 1) `CHK(rb, 1'b1)
            `W(2)
            `CHK(oe, 1'b0)
            drive(i, 1'b0);
            `W(10)
            `P(rd)
            `W(3)
            `CHK(fc, 3'h0)
            `W(100 + {$random(seed)} % 60)
        end
        for (k = 0; k < 4; k = k + 1) begin
            ilim = k;
            `W(6)
            `P(raised)
            `WAITFOR(ssi === 1'b1 || ss3 === 1'b1)
            `CHK(ssi, k != 3)
            `CHK(ss3, k == 3)
            `WAITFOR(ssi === 1'b0 && ss3 === 1'b0)
        end
        `P(nbf)
        `W(3)
        `CHK(nbo, 1'b1)
        bshort = 1'b1;
        `W(10)
        `CHK(lin, 1'b1)
        bshort = 1'b0;
        bdet = 1'b1;
        `WAITFOR(nbo === 1'b0)
        `CHK(nbo, 1'b0)
        {eoc, term, bflt} = 3'h7;
        `WAITFOR(cs === 2'h2)
        `CHK(cs, 2'h2)
        `WAITFOR(det === 1'b1)
        `CHK(det, 1'b1)
        term = 1'b0;
        `WAITFOR(det === 1'b0)
        `W(10)
        `CHK(fc, 3'h0)
        nrst_i = 1'b0;
        `W(4)
        nrst_i = 1'b1;
        `WAITFOR(hiz === 1'b1)
        `CHK(fc, 3'h7)
        `CHK(t15, 1'b1)
        end_sim;
    end
endmodule // testbench
